// [pkg/dpps_consts.svh]
`ifndef DPPS_CONSTS_SVH
`define DPPS_CONSTS_SVH

// ********************************
// Clock and timing
// ********************************
`define DPPS_CLK_MHZ 100
`define DPPS_RST_HOLD_NS 200
`define DPPS_RST_CYC ((`DPPS_RST_HOLD_NS * `DPPS_CLK_MHZ + 999) / 1000)

// ********************************
// Pin positions within the GPIO group
// ********************************
`define DPPS_DATA_GPIO 4
`define DPPS_CLK_GPIO 5

// ********************************
// Register offsets, fields, reset values
// ********************************
`define DPPS_REG_CTRL 4'h0
`define DPPS_REG_STAT 4'h1
`define DPPS_CTRL_LED 0
`define DPPS_CTRL_G4OUT 1
`define DPPS_CTRL_G4OE 2
`define DPPS_CTRL_OFF 3
`define DPPS_CTRL_SHDN 4
`define DPPS_CTRL_RST 8'h00

// ********************************
// Link frame and opcodes
// ********************************
`define DPPS_CMD_BITS 8
`define DPPS_REPLY_BITS 8
`define DPPS_OP_CONNECT 4'h1
`define DPPS_OP_DISCONNECT 4'h2
`define DPPS_OP_RESET 4'h3
`define DPPS_OP_HALT 4'h4
`define DPPS_OP_RESUME 4'h5
`define DPPS_OP_STATUS 4'h6
`define DPPS_OP_BKPT_SET 4'h7
`define DPPS_OP_BKPT_CLR 4'h8
`define DPPS_OP_LED_BLOCK 4'h9

`endif

// [pkg/dpps_pkg.sv]
package dpps_pkg;

	// Register port request
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} dpps_bus_t;

	// Part lifecycle
	typedef enum logic [1:0] {LIFE_FACTORY = 2'b00, LIFE_USER = 2'b01, LIFE_RUN = 2'b10} dpps_life_t;

	// Boot and power sequence
	typedef enum logic [1:0] {B_RESET = 2'b00, B_BOOT = 2'b01, B_RUN = 2'b11, B_SHDN = 2'b10} dpps_boot_t;

	// Link frame
	typedef enum logic [1:0] {L_IDLE = 2'b00, L_CMD = 2'b01, L_PAY = 2'b11, L_REPLY = 2'b10} dpps_link_t;

endpackage

// [rtl/dpps_sync.sv]
`timescale 1ns/10ps
module dpps_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;

	// Two-stage synchroniser, idle level high
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_q <= '1;
			dout <= '1;
		end
		else
		begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

// [rtl/dpps_bkpt_mem.sv]
`timescale 1ns/10ps
module dpps_bkpt_mem #(
	parameter int DEPTH = 4,
	parameter int AW = 16,
	parameter int IW = 2
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clr,
	input wire logic wr,
	input wire logic [IW-1:0] wrIdx,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [AW-1:0] matchAddr,
	output logic hit_q
);
	logic [AW-1:0] addr_q [DEPTH];
	logic [DEPTH-1:0] valid_q;
	logic [DEPTH-1:0] match;

	// ********************************
	// Breakpoint entries
	// ********************************
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++)
		begin : gEntry
			always_ff @(posedge clk)
			begin
				if (reset || clr)
				begin
					valid_q[i] <= 1'b0;
					addr_q[i] <= '0;
				end
				else if (wr && wrIdx == IW'(i))
				begin
					valid_q[i] <= 1'b1;
					addr_q[i] <= wrAddr;
				end
			end
			assign match[i] = valid_q[i] && addr_q[i] == matchAddr;
		end
	endgenerate

	// Registered match result
	always_ff @(posedge clk)
	begin
		if (reset || clr)
			hit_q <= 1'b0;
		else
			hit_q <= |match;
	end
endmodule

// [rtl/dpps_debug_port.sv]
`timescale 1ns/10ps
`include "dpps_consts.svh"

// How it works
// - Link is one sampled host clock pin plus one bidirectional data pin.
// - A software off bit silences the port on User and Run parts.
// - While connected the port owns the clock and data pins; core halts.
// - LED sink stays off during a session whatever software asks.
// - Disconnect clears breakpoints and LED block and resumes the core, all in the same cycle.
// - Connect is refused while the LED sink is on.
// - Data pin is an application GPIO whenever no session is open.
// - Reset command resets digital logic and registers, then reruns boot.
// - Factory parts boot without reloading code RAM.
// - User parts boot and load the stored user region into code RAM.
// - Only power reset, shutdown wakeup or reset command start a reset.
// - Shutdown powers down digital logic, losing the session and code RAM.
// - Any GPIO pulled low wakes the part from shutdown.
// - Run parts refuse all debug traffic.
// - Application LED requests stay masked until disconnect.
module dpps_debug_port #(
	parameter int GPIO_W = 8,
	parameter int ADDR_W = 16,
	parameter int BKPT_DEPTH = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire dpps_pkg::dpps_bus_t busReq,
	output logic [7:0] rdData_q,
	input wire logic [GPIO_W-1:0] gpioIn,
	output logic dbgDataOut_q,
	output logic dbgDataOe_q,
	output logic pin4Out_q,
	output logic pin4Oe_q,
	output logic ledSinkEn_q,
	input wire dpps_pkg::dpps_life_t lifeState,
	input wire logic [ADDR_W-1:0] coreAddr,
	output logic coreHalt_q,
	output logic digitalReset_q,
	output logic bootStart_q,
	output logic loadUserRegion_q,
	output logic powerDown_q
);
	import dpps_pkg::*;

	localparam int RST_CYC = `DPPS_RST_CYC;
	localparam int RCW = $clog2(RST_CYC + 1);
	localparam int IDX_W = (BKPT_DEPTH > 1) ? $clog2(BKPT_DEPTH) : 1;
	localparam logic [7:0] CTRL_RST = `DPPS_CTRL_RST;

	logic [GPIO_W-1:0] gpioSync;
	logic dbgClk;
	logic dbgDat;
	logic clkPrev_q;
	logic clkRise;
	logic clkFall;
	dpps_boot_t bootState_q;
	logic [RCW-1:0] rstCnt_q;
	dpps_link_t linkState_q;
	logic [4:0] bitCnt_q;
	logic [7:0] cmd_q;
	logic [7:0] cmdNext;
	logic [ADDR_W-1:0] pay_q;
	logic [7:0] reply_q;
	logic cmdStb_q;
	logic [3:0] cmdOp_q;
	logic [3:0] cmdArg_q;
	logic connected_q;
	logic ledBlock_q;
	logic ctrlLed_q;
	logic g4Out_q;
	logic g4Oe_q;
	logic portOff_q;
	logic shdnReq;
	logic portLive;
	logic wake;
	logic dbgResetCmd;
	logic rstReq;
	logic sysClr;
	logic sessClr;
	logic bkptClr;
	logic bkptWr;
	logic bkptHit;
	logic opConnect;
	logic opDisconnect;
	logic [7:0] statusByte;

	// ********************************
	// Pin sampling
	// ********************************
	dpps_sync #(.W(GPIO_W)) uSync (
		.clk(clk),
		.reset(reset),
		.din(gpioIn),
		.dout(gpioSync)
	);

	assign dbgClk = gpioSync[`DPPS_CLK_GPIO];
	assign dbgDat = gpioSync[`DPPS_DATA_GPIO];

	// Clock pin edge finder
	always_ff @(posedge clk)
	begin
		if (reset)
			clkPrev_q <= 1'b1;
		else
			clkPrev_q <= dbgClk;
	end

	assign clkRise = dbgClk && !clkPrev_q;
	assign clkFall = !dbgClk && clkPrev_q;

	// ********************************
	// Reset sources and gating
	// ********************************
	assign wake = !(&gpioSync);
	assign dbgResetCmd = cmdStb_q && cmdOp_q == `DPPS_OP_RESET && connected_q;
	assign rstReq = (bootState_q == B_RUN && dbgResetCmd) || (bootState_q == B_SHDN && wake);
	assign sysClr = reset || rstReq;
	assign sessClr = reset || (bootState_q == B_RUN && shdnReq) || bootState_q == B_SHDN;
	assign portLive = bootState_q == B_RUN && lifeState != LIFE_RUN
		&& !(portOff_q && lifeState != LIFE_FACTORY);

	// ********************************
	// Boot and power sequencer
	// ********************************
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			bootState_q <= B_RESET;
			rstCnt_q <= '0;
			digitalReset_q <= 1'b1;
			bootStart_q <= 1'b0;
			loadUserRegion_q <= 1'b0;
			powerDown_q <= 1'b0;
		end
		else
		begin
			bootStart_q <= 1'b0;
			loadUserRegion_q <= 1'b0;
			case (bootState_q)
				B_RESET:
				begin
					rstCnt_q <= rstCnt_q + RCW'(1);
					if (rstCnt_q == RCW'(RST_CYC - 1))
					begin
						bootState_q <= B_BOOT;
						digitalReset_q <= 1'b0;
					end
				end
				B_BOOT:
				begin
					bootState_q <= B_RUN;
					bootStart_q <= 1'b1;
					loadUserRegion_q <= lifeState != LIFE_FACTORY;
				end
				B_RUN:
				begin
					if (rstReq)
					begin
						bootState_q <= B_RESET;
						rstCnt_q <= '0;
						digitalReset_q <= 1'b1;
					end
					else if (shdnReq)
					begin
						bootState_q <= B_SHDN;
						powerDown_q <= 1'b1;
					end
				end
				B_SHDN:
				begin
					if (rstReq)
					begin
						bootState_q <= B_RESET;
						rstCnt_q <= '0;
						digitalReset_q <= 1'b1;
						powerDown_q <= 1'b0;
					end
				end
				default:
					bootState_q <= B_RESET;
			endcase
		end
	end

	// ********************************
	// Link framing
	// ********************************
	assign cmdNext = {dbgDat, cmd_q[7:1]};
	assign statusByte = {lifeState, portOff_q, ledSinkEn_q, ledBlock_q, coreHalt_q, connected_q, 1'b1};

	always_ff @(posedge clk)
	begin
		if (sessClr || !portLive)
		begin
			linkState_q <= L_IDLE;
			bitCnt_q <= '0;
			cmd_q <= 8'h00;
			pay_q <= '0;
			reply_q <= 8'h00;
			cmdStb_q <= 1'b0;
			cmdOp_q <= 4'h0;
			cmdArg_q <= 4'h0;
			dbgDataOut_q <= 1'b0;
			dbgDataOe_q <= 1'b0;
		end
		else
		begin
			cmdStb_q <= 1'b0;
			case (linkState_q)
				L_IDLE:
				begin
					if (clkRise && !dbgDat)
					begin
						linkState_q <= L_CMD;
						bitCnt_q <= '0;
					end
				end
				L_CMD:
				begin
					if (clkRise)
					begin
						cmd_q <= cmdNext;
						bitCnt_q <= bitCnt_q + 5'd1;
						if (bitCnt_q == 5'(`DPPS_CMD_BITS - 1))
						begin
							cmdOp_q <= cmdNext[7:4];
							cmdArg_q <= cmdNext[3:0];
							bitCnt_q <= '0;
							if (cmdNext[7:4] == `DPPS_OP_BKPT_SET)
								linkState_q <= L_PAY;
							else if (cmdNext[7:4] == `DPPS_OP_STATUS && connected_q)
							begin
								linkState_q <= L_REPLY;
								reply_q <= statusByte;
							end
							else
							begin
								linkState_q <= L_IDLE;
								cmdStb_q <= 1'b1;
							end
						end
					end
				end
				L_PAY:
				begin
					if (clkRise)
					begin
						pay_q <= {dbgDat, pay_q[ADDR_W-1:1]};
						bitCnt_q <= bitCnt_q + 5'd1;
						if (bitCnt_q == 5'(ADDR_W - 1))
						begin
							linkState_q <= L_IDLE;
							cmdStb_q <= 1'b1;
						end
					end
				end
				L_REPLY:
				begin
					if (clkFall && bitCnt_q != 5'(`DPPS_REPLY_BITS))
					begin
						dbgDataOut_q <= reply_q[0];
						dbgDataOe_q <= 1'b1;
						reply_q <= {1'b0, reply_q[7:1]};
						bitCnt_q <= bitCnt_q + 5'd1;
					end
					else if (clkRise && bitCnt_q == 5'(`DPPS_REPLY_BITS))
					begin
						linkState_q <= L_IDLE;
						dbgDataOe_q <= 1'b0;
						dbgDataOut_q <= 1'b0;
					end
				end
				default:
					linkState_q <= L_IDLE;
			endcase
		end
	end

	// ********************************
	// Session and LED block
	// ********************************
	// Pending LED request also refuses, so the sink never turns on with the session
	assign opConnect = cmdStb_q && cmdOp_q == `DPPS_OP_CONNECT && !ctrlLed_q;
	assign opDisconnect = cmdStb_q && cmdOp_q == `DPPS_OP_DISCONNECT && connected_q;

	always_ff @(posedge clk)
	begin
		if (sessClr)
		begin
			connected_q <= 1'b0;
			ledBlock_q <= 1'b0;
		end
		else if (opConnect && !connected_q && !ledSinkEn_q)
			connected_q <= 1'b1;
		else if (opDisconnect)
		begin
			connected_q <= 1'b0;
			ledBlock_q <= 1'b0;
		end
		else if (cmdStb_q && cmdOp_q == `DPPS_OP_LED_BLOCK && connected_q)
			ledBlock_q <= cmdArg_q[0];
	end

	// Core halt control
	always_ff @(posedge clk)
	begin
		if (sessClr)
			coreHalt_q <= 1'b0;
		else if (opConnect && !connected_q && !ledSinkEn_q)
			coreHalt_q <= 1'b1;
		else if (opDisconnect)
			coreHalt_q <= 1'b0;
		else if (cmdStb_q && connected_q && cmdOp_q == `DPPS_OP_HALT)
			coreHalt_q <= 1'b1;
		else if (cmdStb_q && connected_q && cmdOp_q == `DPPS_OP_RESUME)
			coreHalt_q <= 1'b0;
		else if (bkptHit && bootState_q == B_RUN)
			coreHalt_q <= 1'b1;
	end

	// ********************************
	// Breakpoints
	// ********************************
	assign bkptClr = sessClr || opDisconnect
		|| (cmdStb_q && connected_q && cmdOp_q == `DPPS_OP_BKPT_CLR);
	assign bkptWr = cmdStb_q && connected_q && cmdOp_q == `DPPS_OP_BKPT_SET;

	dpps_bkpt_mem #(.DEPTH(BKPT_DEPTH), .AW(ADDR_W), .IW(IDX_W)) uBkpt (
		.clk(clk),
		.reset(reset),
		.clr(bkptClr),
		.wr(bkptWr),
		.wrIdx(cmdArg_q[IDX_W-1:0]),
		.wrAddr(pay_q),
		.matchAddr(coreAddr),
		.hit_q(bkptHit)
	);

	// ********************************
	// Software registers
	// ********************************
	assign shdnReq = busReq.wr && busReq.addr == `DPPS_REG_CTRL && busReq.wdata[`DPPS_CTRL_SHDN] && !powerDown_q;

	always_ff @(posedge clk)
	begin
		if (sysClr || sessClr)
		begin
			ctrlLed_q <= CTRL_RST[`DPPS_CTRL_LED];
			g4Out_q <= 1'b0;
			g4Oe_q <= 1'b0;
		end
		else if (busReq.wr && busReq.addr == `DPPS_REG_CTRL)
		begin
			ctrlLed_q <= busReq.wdata[`DPPS_CTRL_LED];
			g4Out_q <= busReq.wdata[`DPPS_CTRL_G4OUT];
			g4Oe_q <= busReq.wdata[`DPPS_CTRL_G4OE];
		end
	end

	// Port off bit is sticky until reset or a shutdown request
	always_ff @(posedge clk)
	begin
		if (sysClr || sessClr)
			portOff_q <= 1'b0;
		else if (busReq.wr && busReq.addr == `DPPS_REG_CTRL && busReq.wdata[`DPPS_CTRL_OFF])
			portOff_q <= 1'b1;
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (reset || !busReq.rd)
			rdData_q <= 8'h00;
		else if (busReq.addr == `DPPS_REG_CTRL)
			rdData_q <= {3'b000, 1'b0, portOff_q, g4Oe_q, g4Out_q, ctrlLed_q};
		else if (busReq.addr == `DPPS_REG_STAT)
			rdData_q <= {lifeState, gpioSync[`DPPS_DATA_GPIO], ledSinkEn_q, ledBlock_q, coreHalt_q, connected_q,
				powerDown_q};
		else
			rdData_q <= 8'h00;
	end

	// ********************************
	// Pin drivers
	// ********************************
	always_ff @(posedge clk)
	begin
		if (sessClr)
			ledSinkEn_q <= 1'b0;
		else
			ledSinkEn_q <= ctrlLed_q && !ledBlock_q && !connected_q;
	end

	always_ff @(posedge clk)
	begin
		if (sessClr || connected_q)
		begin
			pin4Out_q <= 1'b0;
			pin4Oe_q <= 1'b0;
		end
		else
		begin
			pin4Out_q <= g4Out_q;
			pin4Oe_q <= g4Oe_q;
		end
	end
endmodule

// [tb/dpps_debug_port_props.sv]
`timescale 1ns/10ps
// ********************************
// Port checks
// ********************************
module dpps_debug_port_props #(
	parameter int GPIO_W = 8,
	parameter int ADDR_W = 16,
	parameter int BKPT_DEPTH = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire dpps_pkg::dpps_bus_t busReq,
	input wire logic [7:0] rdData_q,
	input wire logic [GPIO_W-1:0] gpioIn,
	input wire logic dbgDataOut_q,
	input wire logic dbgDataOe_q,
	input wire logic pin4Out_q,
	input wire logic pin4Oe_q,
	input wire logic ledSinkEn_q,
	input wire dpps_pkg::dpps_life_t lifeState,
	input wire logic [ADDR_W-1:0] coreAddr,
	input wire logic coreHalt_q,
	input wire logic digitalReset_q,
	input wire logic bootStart_q,
	input wire logic loadUserRegion_q,
	input wire logic powerDown_q
);
	import dpps_pkg::*;
	logic [4:0] rstCnt_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Length of each digital reset
	always_ff @(posedge clk)
	begin
		if (reset || !digitalReset_q)
			rstCnt_q <= 5'h0;
		else
			rstCnt_q <= rstCnt_q + 5'h1;
	end
	property p_rst_len;
		$fell(digitalReset_q) |-> rstCnt_q inside {[5'h13:5'h15]};
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset hold length wrong");
	property p_boot;
		$fell(digitalReset_q) |-> ##[0:1] bootStart_q;
	endproperty
	a_boot: assert property (p_boot) else $error("no boot after reset");
	property p_boot_cause;
		bootStart_q |-> $past(digitalReset_q) || $past(digitalReset_q, 2);
	endproperty
	a_boot_cause: assert property (p_boot_cause) else $error("boot without reset");
	property p_factory;
		bootStart_q && lifeState == LIFE_FACTORY |-> !loadUserRegion_q;
	endproperty
	a_factory: assert property (p_factory) else $error("factory boot loaded code ram");
	property p_user;
		bootStart_q && lifeState == LIFE_USER |-> loadUserRegion_q;
	endproperty
	a_user: assert property (p_user) else $error("user boot did not load");
	property p_wake;
		$fell(powerDown_q) |-> ##[0:1] digitalReset_q;
	endproperty
	a_wake: assert property (p_wake) else $error("wake without reset");
	property p_down;
		powerDown_q |-> !ledSinkEn_q && !pin4Oe_q && !dbgDataOe_q && !coreHalt_q;
	endproperty
	a_down: assert property (p_down) else $error("logic active in shutdown");
	property p_led_block;
		coreHalt_q |-> !ledSinkEn_q;
	endproperty
	a_led_block: assert property (p_led_block) else $error("led on during session");
	property p_conn_led;
		$rose(coreHalt_q) |-> !$past(ledSinkEn_q);
	endproperty
	a_conn_led: assert property (p_conn_led) else $error("connect while led on");
	property p_pin_owner;
		dbgDataOe_q |-> !pin4Oe_q;
	endproperty
	a_pin_owner: assert property (p_pin_owner) else $error("data pin driven twice");
	property p_run;
		(lifeState == LIFE_RUN) [*4] |-> !dbgDataOe_q;
	endproperty
	a_run: assert property (p_run) else $error("run part replied");
endmodule

bind dpps_debug_port dpps_debug_port_props #(.GPIO_W(GPIO_W), .ADDR_W(ADDR_W), .BKPT_DEPTH(BKPT_DEPTH)) u_props (
	.clk(clk), .reset(reset), .busReq(busReq), .rdData_q(rdData_q), .gpioIn(gpioIn),
	.dbgDataOut_q(dbgDataOut_q), .dbgDataOe_q(dbgDataOe_q), .pin4Out_q(pin4Out_q), .pin4Oe_q(pin4Oe_q),
	.ledSinkEn_q(ledSinkEn_q), .lifeState(lifeState), .coreAddr(coreAddr), .coreHalt_q(coreHalt_q),
	.digitalReset_q(digitalReset_q), .bootStart_q(bootStart_q), .loadUserRegion_q(loadUserRegion_q),
	.powerDown_q(powerDown_q));

// [tb/dpps_host_model.sv]
`timescale 1ns/10ps
`include "dpps_consts.svh"
// ********************************
// Debug adapter on the two link pins
// ********************************
module dpps_host_model (
	output logic dbgClk,
	output logic hostData,
	output logic hostOe,
	input wire logic dataLine
);
	logic [7:0] junk;
	// Clock and data idle high between frames
	initial
	begin
		dbgClk = 1'h1;
		hostData = 1'h1;
		hostOe = 1'h1;
	end
	task automatic bitOut(input logic b);
		dbgClk = 1'h0;
		hostData = b;
		#40;
		dbgClk = 1'h1;
		#40;
	endtask
	// Reply bits are read just before each rising edge
	task automatic frame(input logic [7:0] cmd, input logic reply, output logic [7:0] rep);
		int k;
		rep = 8'h00;
		bitOut(1'h0);
		for (k = 0; k < 8; k++)
			bitOut(cmd[k]);
		if (reply)
		begin
			hostOe = 1'h0;
			for (k = 0; k < 8; k++)
			begin
				dbgClk = 1'h0;
				#39;
				rep[k] = dataLine;
				#1;
				dbgClk = 1'h1;
				#40;
			end
			bitOut(1'h1);
			hostOe = 1'h1;
		end
		hostData = 1'h1;
		#80;
	endtask
	// Breakpoint frame: command byte, then address LSB first
	task automatic bkpt(input logic [1:0] idx, input logic [15:0] ad);
		int k;
		logic [23:0] w;
		w = {ad, `DPPS_OP_BKPT_SET, 2'h0, idx};
		bitOut(1'h0);
		for (k = 0; k < 24; k++)
			bitOut(w[k]);
		hostData = 1'h1;
		#80;
	endtask
	task automatic connect();
		frame({`DPPS_OP_CONNECT, 4'h0}, 1'h0, junk);
		frame({`DPPS_OP_LED_BLOCK, 4'h1}, 1'h0, junk);
	endtask
	task automatic disconnect();
		frame({`DPPS_OP_BKPT_CLR, 4'h0}, 1'h0, junk);
		frame({`DPPS_OP_DISCONNECT, 4'h0}, 1'h0, junk);
	endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/10ps
`include "dpps_consts.svh"
// ********************************
// Bench
// ********************************
module tb;
	import dpps_pkg::*;
	logic clk = 1'h0;
	logic reset = 1'h1;
	dpps_bus_t busReq = '0;
	dpps_life_t lifeState = LIFE_FACTORY;
	logic [15:0] coreAddr = 16'h0000;
	logic [7:0] appPins = 8'hff;
	logic [7:0] rdData_q, gpioIn, v;
	logic dbgDataOut_q, dbgDataOe_q, pin4Out_q, pin4Oe_q, ledSinkEn_q, coreHalt_q;
	logic digitalReset_q, bootStart_q, loadUserRegion_q, powerDown_q, hClk, hDat, hOe, dLine, r;
	logic [3:0] a;
	logic [15:0] ba;
	int bad_count = 0;
	int comparisons = 0;
	int b;
	always #5 clk = ~clk;
	// Data line has a pull-up
	assign dLine = dbgDataOe_q ? dbgDataOut_q : (hOe ? hDat : 1'h1);
	assign gpioIn = {appPins[7:6], hClk, dLine, appPins[3:0]};
	dpps_debug_port DUT (.clk(clk), .reset(reset), .busReq(busReq), .rdData_q(rdData_q), .gpioIn(gpioIn),
		.dbgDataOut_q(dbgDataOut_q), .dbgDataOe_q(dbgDataOe_q), .pin4Out_q(pin4Out_q), .pin4Oe_q(pin4Oe_q),
		.ledSinkEn_q(ledSinkEn_q), .lifeState(lifeState), .coreAddr(coreAddr), .coreHalt_q(coreHalt_q),
		.digitalReset_q(digitalReset_q), .bootStart_q(bootStart_q), .loadUserRegion_q(loadUserRegion_q),
		.powerDown_q(powerDown_q));
	dpps_host_model host (.dbgClk(hClk), .hostData(hDat), .hostOe(hOe), .dataLine(dLine));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge clk);
		busReq <= '{1'h1, 1'h0, ad, d};
		@(posedge clk);
		busReq <= '0;
		cyc(2);
	endtask
	task automatic rd(input logic [3:0] ad, output logic [7:0] d);
		@(posedge clk);
		busReq <= '{1'h0, 1'h1, ad, 8'h00};
		@(posedge clk);
		busReq <= '0;
		#1;
		d = rdData_q;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chkb(input logic g, input logic e);
		chk({7'h00, g}, {7'h00, e});
	endtask
	task automatic waitBoot();
		int n;
		n = 0;
		while (bootStart_q !== 1'h1 && n < 200)
		begin
			cyc(1);
			n++;
		end
		chkb(bootStart_q, 1'h1);
	endtask
	task automatic setLife(input dpps_life_t l);
		@(posedge clk);
		lifeState <= l;
	endtask
	task automatic tdone(input string s);
		$display("test %0s done", s);
	endtask
	function automatic logic [7:0] statExp(input logic c, input logic h, input logic k, input logic s);
		return {lifeState, 1'h0, s, k, h, c, 1'h1};
	endfunction
	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#400000;
		bad_count++;
		print_verdict();
	end
	initial
	begin
		void'($urandom(89960));
		repeat (8) @(posedge clk);
		reset <= 1'h0;
		waitBoot();
		rd(`DPPS_REG_CTRL, v);
		chk(v, `DPPS_CTRL_RST);
		a = 4'(2 + $urandom_range(13));
		rd(a, v);
		chk(v, 8'h00);
		tdone("regs");
		r = 1'($urandom_range(1));
		wr(`DPPS_REG_CTRL, {5'h00, 1'h1, r, 1'h1});
		chkb(pin4Out_q, r);
		chkb(ledSinkEn_q, 1'h1);
		host.connect();
		cyc(8);
		chkb(coreHalt_q, 1'h0);
		wr(`DPPS_REG_CTRL, {5'h00, 1'h1, r, 1'h0});
		host.connect();
		cyc(8);
		chkb(coreHalt_q, 1'h1);
		chkb(pin4Oe_q, 1'h0);
		wr(`DPPS_REG_CTRL, 8'h01);
		chkb(ledSinkEn_q, 1'h0);
		host.frame({`DPPS_OP_STATUS, 4'h0}, 1'h1, v);
		chk(v, statExp(1'h1, 1'h1, 1'h1, 1'h0));
		tdone("connect");
		for (int i = 0; i < 2; i++)
		begin
			setLife(dpps_life_t'(i));
			host.frame({`DPPS_OP_RESET, 4'h0}, 1'h0, v);
			chkb(digitalReset_q, 1'h1);
			waitBoot();
			chkb(loadUserRegion_q, 1'(i));
			rd(`DPPS_REG_CTRL, v);
			chk(v, 8'h00);
		end
		tdone("debug reset");
		ba = 16'($urandom) | 16'h8000;
		host.bkpt(2'($urandom_range(3)), ba);
		host.frame({`DPPS_OP_RESUME, 4'h0}, 1'h0, v);
		cyc(4);
		chkb(coreHalt_q, 1'h0);
		host.frame({`DPPS_OP_HALT, 4'h0}, 1'h0, v);
		cyc(4);
		chkb(coreHalt_q, 1'h1);
		host.frame({`DPPS_OP_RESUME, 4'h0}, 1'h0, v);
		@(posedge clk);
		coreAddr <= ba;
		cyc(4);
		chkb(coreHalt_q, 1'h1);
		tdone("breakpoint");
		wr(`DPPS_REG_CTRL, 8'h01);
		host.disconnect();
		cyc(8);
		chkb(coreHalt_q, 1'h0);
		chkb(ledSinkEn_q, 1'h1);
		wr(`DPPS_REG_CTRL, 8'h08);
		host.connect();
		cyc(8);
		chkb(coreHalt_q, 1'h0);
		wr(`DPPS_REG_CTRL, 8'h10);
		chkb(powerDown_q, 1'h1);
		b = $urandom_range(5);
		@(posedge clk);
		appPins[b < 4 ? b : b + 2] <= 1'h0;
		repeat (6) @(posedge clk);
		appPins <= 8'hff;
		waitBoot();
		chkb(powerDown_q, 1'h0);
		rd(`DPPS_REG_CTRL, v);
		chk(v, 8'h00);
		tdone("shutdown");
		setLife(LIFE_RUN);
		host.connect();
		cyc(8);
		chkb(coreHalt_q, 1'h0);
		host.frame({`DPPS_OP_STATUS, 4'h0}, 1'h1, v);
		chk(v, 8'hff);
		tdone("run part");
		print_verdict();
	end
endmodule
